/* File: rtl/uepmc_engine.sv */
// Endpoint mode and count engine: register slave, token answers and transaction updates
// Operation
// RULE1: Mode register low four bits choose the answer to SETUP, IN and OUT.
// RULE2: Acknowledge flag bit 4 sets when a transaction ends with ACK.
// RULE3: Stall bit 7 stalls OUT in ack-IN mode and IN in ack-OUT mode; code stalls OUT in ack-OUT mode and IN in ack-IN mode.
// RULE4: Firmware keeps stall bit clear in all other modes.
// RULE5: Firmware writes zero to reserved bits 5 and 6 of data endpoints.
// RULE6: Firmware loads IN byte count, 0 to 8, before an IN.
// RULE7: OUT and SETUP write received bytes plus two CRC bytes into count.
// RULE8: Data-valid bit 6 follows the CRC check; interrupt raised either way.
// RULE9: Count bit 7 is the data toggle; received toggle copied on OUT/SETUP.
// RULE10: Endpoint zero count locks on OUT/SETUP update; others never lock.
// RULE11: Update rewrites mode and count, raises interrupt, locks endpoint zero.
// RULE12: SETUP point forces setup flag high until the data phase ends.
// RULE13: A read after the update unlocks endpoint zero registers.
// RULE14: All endpoints reset into the disabled mode.
// RULE15: Disabled ignores all; isochronous out always takes data; iso in sends count.
// RULE16: Control modes accept SETUP with their own IN and OUT answers.
// RULE17: Valid SETUP in a SETUP-taking mode is ACKed and mode becomes NAKing.
// RULE18: Data modes NAK or ACK OUT and IN, ACK modes fall to NAK modes.
// RULE19: Status-in and status-out modes drop to their NAK partner after ACK; code drops M_ACK_OUT_ST_IN and M_ACK_IN_ST_OUT to their NAK partners.
// RULE20: Status check ACKs only a zero-length OUT with toggle one, else STALL.
// RULE21: Control endpoint records SETUP, IN and OUT reception in status flags.
// RULE22: Firmware puts no SETUP-taking mode on a data endpoint.
// RULE23: Endpoint zero mode locks on engine update; other modes never lock.
// RULE24: While setup flag is set, endpoint zero buffer writes are blocked.
`default_nettype none
`include "uepmc_cfg.svh"
module uepmc_engine import uepmc_pkg::*; #(
  parameter int EP_BYTES = `UEPMC_EP_BYTES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [8:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Transaction reports from the serial engine
  input wire logic txn_valid,
  input wire logic [1:0] txn_pid,
  input wire logic [2:0] txn_ep,
  input wire logic [5:0] txn_count,
  input wire logic txn_crc_ok,
  input wire logic txn_toggle,
  input wire logic setup_start,
  input wire logic in_ack,
  // Answers to the serial engine
  output logic ans_valid,
  output uepmc_resp_e ans_code,
  output logic [5:0] ans_count,
  output logic ans_toggle,
  // Firmware side
  output logic [4:0] ep_int,
  output logic ep0_buf_lock
);
  localparam int NUM_EP = 5;
  localparam logic [2:0] EP_LIMIT = 3'(NUM_EP);
  localparam logic [5:0] MAX_RX = 6'(EP_BYTES) + `UEPMC_CRC_BYTES;
  localparam logic [6:0] CNT_IDX [NUM_EP] = '{`UEPMC_IDX_EP0_CNT, `UEPMC_IDX_EP1_CNT,
    `UEPMC_IDX_EP2_CNT, `UEPMC_IDX_EP3_CNT, `UEPMC_IDX_EP4_CNT};
  localparam logic [6:0] MODE_IDX [NUM_EP] = '{`UEPMC_IDX_EP0_MODE, `UEPMC_IDX_EP1_MODE,
    `UEPMC_IDX_EP2_MODE, `UEPMC_IDX_EP3_MODE, `UEPMC_IDX_EP4_MODE};

  logic [7:0] ep_mode [NUM_EP];
  logic [7:0] ep_cnt [NUM_EP];
  logic [8:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0, setup_force, last_ep_valid;
  logic [2:0] pend_ep, last_ep;
  uepmc_state_e state, next_state;

  // Write channel: address and data held until both are in
  logic do_wr, wr_hit, rd_hit, ar_take;
  logic [6:0] wr_idx, rd_idx;
  logic [NUM_EP-1:0] wr_mode_hit, wr_cnt_hit, rd_mode_hit, rd_cnt_hit;
  logic [7:0] rd_byte;
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = aw_addr[8:2];
  assign rd_idx = s_axi_araddr[8:2];
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_hit = |{wr_mode_hit, wr_cnt_hit};
  assign rd_hit = |{rd_mode_hit, rd_cnt_hit};

  always_comb begin
    rd_byte = 8'h00;
    for (int e = 0; e < NUM_EP; e++) begin
      if (rd_mode_hit[e]) rd_byte = ep_mode[e];
      if (rd_cnt_hit[e]) rd_byte = ep_cnt[e];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UEPMC_RESP_OKAY;
      aw_addr <= 9'h000;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `UEPMC_RESP_OKAY : `UEPMC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UEPMC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? `UEPMC_RESP_OKAY : `UEPMC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Transaction side
  logic take, ia_take, is_ctrl, rx_good, status_ok, upd_mode_now, dec_ack, dec_flag;
  logic dec_int, dec_cnt, goes_wait;
  logic [2:0] sel_idx;
  logic [3:0] dec_mode, ia_next;
  logic [7:0] sel_mode, sel_cnt, ia_mode, upd_mode_val, ia_val, mode_val, cnt_val;
  uepmc_resp_e dec_resp;

  assign take = txn_valid && txn_ep < EP_LIMIT;
  assign sel_idx = (txn_ep < EP_LIMIT) ? txn_ep : 3'h0;
  assign sel_mode = ep_mode[sel_idx];
  assign sel_cnt = ep_cnt[sel_idx];
  assign is_ctrl = sel_idx == 3'h0;
  assign rx_good = txn_crc_ok && txn_count <= MAX_RX;
  assign status_ok = txn_count == `UEPMC_CRC_BYTES && txn_toggle; // RULE20
  // Data endpoints have no token flags; bits 6:5 stay zero there
  assign upd_mode_val = {sel_mode[7],
    is_ctrl & (sel_mode[`UEPMC_BIT_IN] | (dec_flag & txn_pid == P_IN)), // RULE21
    is_ctrl & (sel_mode[`UEPMC_BIT_OUT] | (dec_flag & txn_pid == P_OUT)),
    sel_mode[`UEPMC_BIT_ACK] | dec_ack, dec_mode}; // RULE2
  assign upd_mode_now = take && (dec_ack || dec_flag || dec_mode != sel_mode[3:0]);
  assign ia_take = in_ack && state == S_IN_WAIT && !txn_valid;
  assign ia_mode = ep_mode[pend_ep];
  assign ia_next = (ia_mode[3:0] == M_ACK_IN) ? M_NAK_IN :
                   (ia_mode[3:0] == M_ACK_IN_ST_OUT) ? M_NAK_IN_ST_OUT : ia_mode[3:0]; // RULE18
  assign ia_val = {ia_mode[7:5], 1'b1, ia_next}; // RULE2
  assign mode_val = ia_take ? ia_val : upd_mode_val;
  assign cnt_val = {txn_toggle, txn_crc_ok, txn_count}; // RULE7 RULE8 RULE9
  assign goes_wait = take && txn_pid == P_IN && sel_mode[3:0] != M_ISO_IN &&
                     (dec_resp == R_TX0 || dec_resp == R_TXCNT);
  assign next_state = goes_wait ? S_IN_WAIT : (txn_valid || in_ack) ? S_IDLE : state;

  uepmc_resp_decode u_decode (
    .mode_code(sel_mode[3:0]), // RULE1
    .pid(txn_pid),
    .stall(!is_ctrl && sel_mode[`UEPMC_BIT_STALL]),
    .rx_good(rx_good),
    .status_ok(status_ok),
    .resp(dec_resp),
    .next_mode(dec_mode),
    .set_ack(dec_ack),
    .set_flag(dec_flag),
    .int_due(dec_int),
    .upd_cnt(dec_cnt)
  );

  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    assign wr_mode_hit[e] = wr_idx == MODE_IDX[e];
    assign wr_cnt_hit[e] = wr_idx == CNT_IDX[e];
    assign rd_mode_hit[e] = rd_idx == MODE_IDX[e];
    assign rd_cnt_hit[e] = rd_idx == CNT_IDX[e];
    uepmc_ep_reg #(.IS_CTRL(e == 0)) u_reg (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .wr_mode(do_wr && w_lane0 && wr_mode_hit[e]),
      .wr_cnt(do_wr && w_lane0 && wr_cnt_hit[e]),
      .rd_mode(ar_take && rd_mode_hit[e]),
      .rd_cnt(ar_take && rd_cnt_hit[e]),
      .wdata(w_byte),
      .upd_mode((upd_mode_now && sel_idx == e) || (ia_take && pend_ep == e)), // RULE11
      .upd_cnt(take && dec_cnt && sel_idx == e), // RULE11
      .upd_mode_val(mode_val),
      .upd_cnt_val(cnt_val),
      .setup_force(setup_force),
      .setup_set(e == 0 && setup_start), // RULE12
      .mode(ep_mode[e]),
      .cnt(ep_cnt[e])
    );
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      pend_ep <= 3'h0;
      last_ep <= 3'h0;
      last_ep_valid <= 1'b0;
      setup_force <= 1'b0;
      ans_valid <= 1'b0;
      ans_code <= R_IGNORE;
      ans_count <= 6'h00;
      ans_toggle <= 1'b0;
      ep_int <= 5'h00;
      ep0_buf_lock <= 1'b0;
    end else begin
      state <= next_state;
      if (goes_wait) pend_ep <= sel_idx;
      last_ep <= sel_idx;
      last_ep_valid <= take;
      // Start of a new SETUP wins over the end of the old one
      setup_force <= setup_start ||
        (setup_force && !(take && is_ctrl && txn_pid == P_SETUP)); // RULE12
      ans_valid <= take;
      ans_code <= dec_resp;
      ans_count <= (dec_resp == R_TXCNT) ? sel_cnt[5:0] : 6'h00;
      ans_toggle <= sel_cnt[`UEPMC_BIT_TOG]; // RULE9
      ep_int <= 5'((take && dec_int) ? 5'h01 << sel_idx : 5'h00) |
                5'(ia_take ? 5'h01 << pend_ep : 5'h00); // RULE11 RULE8
      ep0_buf_lock <= ep_mode[0][`UEPMC_BIT_SETUP]; // RULE24
    end
  end

  a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
    take && sel_mode[3:0] == M_DISABLED |=> ans_code == R_IGNORE && ep_int == 5'h00)
    else $error("disabled endpoint answered");
  a_setup_ack: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE17
    take && txn_pid == P_SETUP && rx_good && sel_mode[3:0] == M_STALL_INOUT
    |=> ans_code == R_ACK && ep_mode[last_ep][3:0] == M_NAK_INOUT)
    else $error("setup not acked to nak mode");
  a_ack_bit: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE2
    ans_valid && ans_code == R_ACK |-> ep_mode[last_ep][`UEPMC_BIT_ACK])
    else $error("ack flag missing");
  a_rx_count: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
    take && dec_cnt |=> ep_cnt[last_ep][5:0] == $past(txn_count))
    else $error("count not written");
  a_dval_crc: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE8
    take && dec_cnt |=> ep_cnt[last_ep][`UEPMC_BIT_DVAL] == $past(txn_crc_ok)
    && ep_int[last_ep]) else $error("data valid or interrupt wrong");
  a_stall_in: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE3
    take && !is_ctrl && txn_pid == P_IN && sel_mode == 8'h8D |=> ans_code == R_STALL)
    else $error("stall not applied");
  a_status_check: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE20
    take && txn_pid == P_OUT && rx_good && sel_mode[3:0] == M_STATUS_OUT
    |=> ans_code == ($past(status_ok) ? R_ACK : R_STALL)) else $error("status check wrong");
  a_buf_block: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE24
    setup_force |-> ##[1:2] ep0_buf_lock) else $error("buffer not blocked");
  a_in_update: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE11
    ia_take |=> ep_int == 5'h01 << $past(pend_ep)) else $error("in ack without interrupt");
  c_setup_acked: cover property (@(posedge ref_clk) disable iff (!nrst)
    ans_valid && ans_code == R_ACK && last_ep == 3'h0);
  c_in_acked: cover property (@(posedge ref_clk) disable iff (!nrst) ia_take);
  c_status_stall: cover property (@(posedge ref_clk) disable iff (!nrst)
    ans_valid && ans_code == R_STALL);
endmodule : uepmc_engine
`default_nettype wire

/* File: rtl/uepmc_cfg.svh */
// Register indexes, field positions, reset values and counts for the endpoint engine
`ifndef UEPMC_CFG_SVH
`define UEPMC_CFG_SVH

`define UEPMC_IDX_EP0_CNT 7'h11
`define UEPMC_IDX_EP0_MODE 7'h12
`define UEPMC_IDX_EP1_CNT 7'h13
`define UEPMC_IDX_EP1_MODE 7'h14
`define UEPMC_IDX_EP2_CNT 7'h15
`define UEPMC_IDX_EP2_MODE 7'h16
`define UEPMC_IDX_EP3_CNT 7'h41
`define UEPMC_IDX_EP3_MODE 7'h42
`define UEPMC_IDX_EP4_CNT 7'h43
`define UEPMC_IDX_EP4_MODE 7'h44

`define UEPMC_BIT_SETUP 7
`define UEPMC_BIT_STALL 7
`define UEPMC_BIT_IN 6
`define UEPMC_BIT_OUT 5
`define UEPMC_BIT_ACK 4
`define UEPMC_BIT_TOG 7
`define UEPMC_BIT_DVAL 6

`define UEPMC_MODE_RST 8'h00
`define UEPMC_CNT_RST 8'h00
`define UEPMC_CRC_BYTES 6'h02
`define UEPMC_EP_BYTES 8
`define UEPMC_RESP_OKAY 2'h0
`define UEPMC_RESP_SLVERR 2'h2

`endif

/* File: rtl/uepmc_pkg.sv */
// Types shared by the endpoint mode and count engine
`default_nettype none
package uepmc_pkg;
  typedef enum logic [3:0] {
    M_DISABLED = 4'h0, M_NAK_INOUT = 4'h1, M_STATUS_OUT = 4'h2, M_STALL_INOUT = 4'h3,
    M_IGNORE_INOUT = 4'h4, M_ISO_OUT = 4'h5, M_STATUS_IN = 4'h6, M_ISO_IN = 4'h7,
    M_NAK_OUT = 4'h8, M_ACK_OUT = 4'h9, M_NAK_OUT_ST_IN = 4'hA, M_ACK_OUT_ST_IN = 4'hB,
    M_NAK_IN = 4'hC, M_ACK_IN = 4'hD, M_NAK_IN_ST_OUT = 4'hE, M_ACK_IN_ST_OUT = 4'hF
  } uepmc_mode_e;
  typedef enum logic [2:0] {
    R_IGNORE = 3'h0, R_ACK = 3'h1, R_NAK = 3'h2, R_STALL = 3'h3, R_TX0 = 3'h4, R_TXCNT = 3'h5
  } uepmc_resp_e;
  typedef enum logic [1:0] {P_OUT = 2'h0, P_IN = 2'h1, P_SETUP = 2'h2} uepmc_pid_e;
  typedef enum logic [0:0] {S_IDLE = 1'h0, S_IN_WAIT = 1'h1} uepmc_state_e;
endpackage : uepmc_pkg
`default_nettype wire

/* File: rtl/uepmc_resp_decode.sv */
// Token response decoder: mode code and token to handshake, next mode and update strobes
`default_nettype none
module uepmc_resp_decode import uepmc_pkg::*; (
  // Request
  input wire logic [3:0] mode_code,
  input wire logic [1:0] pid,
  input wire logic stall,
  input wire logic rx_good,
  input wire logic status_ok,
  // Decision
  output uepmc_resp_e resp,
  output logic [3:0] next_mode,
  output logic set_ack,
  output logic set_flag,
  output logic int_due,
  output logic upd_cnt
);
  uepmc_mode_e mode;
  logic takes_setup;
  assign mode = uepmc_mode_e'(mode_code);
  assign takes_setup = mode inside {M_NAK_INOUT, M_STATUS_OUT, M_STALL_INOUT, M_IGNORE_INOUT,
    M_STATUS_IN, M_NAK_OUT_ST_IN, M_ACK_OUT_ST_IN, M_NAK_IN_ST_OUT, M_ACK_IN_ST_OUT}; // RULE16

  always_comb begin
    resp = R_IGNORE;
    next_mode = mode_code;
    set_ack = 1'b0;
    set_flag = 1'b0;
    int_due = 1'b0;
    upd_cnt = 1'b0;
    if (pid == P_SETUP) begin
      if (takes_setup) begin // RULE17
        int_due = 1'b1;
        upd_cnt = 1'b1;
        if (rx_good) begin
          resp = R_ACK;
          set_ack = 1'b1;
          next_mode = M_NAK_INOUT;
        end
      end
    end else if (pid == P_OUT) begin
      unique case (mode)
        M_NAK_INOUT, M_NAK_OUT, M_NAK_OUT_ST_IN: if (rx_good) begin // RULE18
          resp = R_NAK;
          set_flag = 1'b1;
          int_due = 1'b1;
        end
        M_STATUS_OUT, M_NAK_IN_ST_OUT, M_ACK_IN_ST_OUT: if (rx_good) begin
          resp = status_ok ? R_ACK : R_STALL; // RULE20
          set_ack = status_ok;
          set_flag = 1'b1;
          int_due = 1'b1;
        end
        M_STALL_INOUT, M_STATUS_IN: begin
          resp = R_STALL;
          set_flag = 1'b1;
          int_due = 1'b1;
        end
        M_ISO_OUT: begin // RULE15
          upd_cnt = 1'b1;
          int_due = 1'b1;
        end
        M_ACK_OUT, M_ACK_OUT_ST_IN: begin
          set_flag = 1'b1;
          int_due = 1'b1;
          if (stall && mode == M_ACK_OUT) begin
            resp = R_STALL; // RULE3
          end else begin
            upd_cnt = 1'b1;
            if (rx_good) begin // RULE19
              resp = R_ACK;
              set_ack = 1'b1;
              next_mode = (mode == M_ACK_OUT) ? M_NAK_OUT : M_NAK_OUT_ST_IN;
            end
          end
        end
        M_DISABLED, M_IGNORE_INOUT, M_ISO_IN, M_NAK_IN, M_ACK_IN: ;
      endcase
    end else if (pid == P_IN) begin
      unique case (mode)
        M_NAK_INOUT, M_NAK_IN, M_NAK_IN_ST_OUT: begin
          resp = R_NAK;
          set_flag = 1'b1;
          int_due = 1'b1;
        end
        M_STATUS_OUT, M_STALL_INOUT: begin
          resp = R_STALL;
          set_flag = 1'b1;
          int_due = 1'b1;
        end
        M_STATUS_IN, M_NAK_OUT_ST_IN, M_ACK_OUT_ST_IN: begin
          resp = R_TX0;
          set_flag = 1'b1;
        end
        M_ISO_IN: begin
          resp = R_TXCNT;
          int_due = 1'b1;
        end
        M_ACK_IN, M_ACK_IN_ST_OUT: begin
          set_flag = 1'b1;
          resp = (stall && mode == M_ACK_IN) ? R_STALL : R_TXCNT; // RULE3
          int_due = resp == R_STALL;
        end
        M_DISABLED, M_IGNORE_INOUT, M_ISO_OUT, M_NAK_OUT, M_ACK_OUT: ;
      endcase
    end
  end
endmodule : uepmc_resp_decode
`default_nettype wire

/* File: rtl/uepmc_ep_reg.sv */
// One endpoint's mode and counter registers with the control endpoint locks
`default_nettype none
`include "uepmc_cfg.svh"
module uepmc_ep_reg import uepmc_pkg::*; #(
  parameter bit IS_CTRL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Processor access
  input wire logic wr_mode,
  input wire logic wr_cnt,
  input wire logic rd_mode,
  input wire logic rd_cnt,
  input wire logic [7:0] wdata,
  // Engine update
  input wire logic upd_mode,
  input wire logic upd_cnt,
  input wire logic [7:0] upd_mode_val,
  input wire logic [7:0] upd_cnt_val,
  input wire logic setup_force,
  input wire logic setup_set,
  // Contents
  output logic [7:0] mode,
  output logic [7:0] cnt
);
  logic mode_lock, cnt_lock, setup_hold;
  logic next_mode_lock, next_cnt_lock, next_setup_hold, setup_busy;
  logic [7:0] next_mode, next_cnt, ctrl_mode, data_mode;

  assign setup_busy = setup_force | setup_hold;
  // Engine update beats a processor write landing in the same cycle, except on control mode bit 7
  assign ctrl_mode[7] = (setup_set | setup_busy) ? 1'b1 : (wr_mode ? wdata[7] : mode[7]); // RULE12
  assign ctrl_mode[6:0] = upd_mode ? upd_mode_val[6:0] :
                          (wr_mode && !mode_lock) ? wdata[6:0] : mode[6:0]; // RULE23
  assign data_mode = upd_mode ? upd_mode_val : wr_mode ? {wdata[7], 2'b00, wdata[4:0]} : mode;
  assign next_mode = IS_CTRL ? ctrl_mode : data_mode;
  assign next_cnt = upd_cnt ? upd_cnt_val : (wr_cnt && !cnt_lock) ? wdata : cnt; // RULE10
  assign next_mode_lock = IS_CTRL & (upd_mode | (mode_lock & !rd_mode)); // RULE13
  assign next_cnt_lock = IS_CTRL & (upd_cnt | (cnt_lock & !rd_cnt)); // RULE13
  assign next_setup_hold = IS_CTRL & (setup_set | (setup_hold & !(rd_mode & !setup_force)));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode <= `UEPMC_MODE_RST; // RULE14
      cnt <= `UEPMC_CNT_RST;
      mode_lock <= 1'b0;
      cnt_lock <= 1'b0;
      setup_hold <= 1'b0;
    end else begin
      mode <= next_mode;
      cnt <= next_cnt;
      mode_lock <= next_mode_lock;
      cnt_lock <= next_cnt_lock;
      setup_hold <= next_setup_hold;
    end
  end

  a_cnt_lock_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE10
    cnt_lock && wr_cnt && !upd_cnt |=> cnt == $past(cnt)) else $error("locked count written");
  a_mode_lock_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE23
    mode_lock && wr_mode && !upd_mode |=> mode[6:0] == $past(mode[6:0]))
    else $error("locked mode written");
  a_lock_ctrl_only: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE10
    !IS_CTRL |-> !mode_lock && !cnt_lock) else $error("data endpoint locked");
  a_unlock_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE13
    cnt_lock && rd_cnt && !upd_cnt ##1 wr_cnt && !upd_cnt |=> cnt == $past(wdata))
    else $error("read did not unlock count");
endmodule : uepmc_ep_reg
`default_nettype wire

/* File: tb/uepmc_host_model.sv */
// Host and serial engine stand-in: reports transactions, acks data sent on IN
`default_nettype none
module uepmc_host_model import uepmc_pkg::*; #(
  parameter int ACK_DLY = 4
) (
  // Clock
  input wire logic ref_clk,
  // Transaction reports
  output logic txn_valid,
  output logic [1:0] txn_pid,
  output logic [2:0] txn_ep,
  output logic [5:0] txn_count,
  output logic txn_crc_ok,
  output logic txn_toggle,
  output logic setup_start,
  output logic in_ack,
  // Answers
  input wire logic ans_valid,
  input wire uepmc_resp_e ans_code,
  input wire logic [5:0] ans_count,
  input wire logic ans_toggle,
  input wire logic [4:0] ep_int
);
  timeunit 1ns;
  timeprecision 1ns;
  uepmc_resp_e got;
  logic [4:0] got_int;
  logic [7:0] got_cnt;
  initial begin
    {txn_valid, txn_pid, txn_ep, txn_count, txn_crc_ok, txn_toggle} = '0;
    {setup_start, in_ack} = '0;
  end
  task automatic send(input logic [1:0] p, input logic [2:0] e, input logic [5:0] c,
    input logic ok, input logic t, input logic s);
    if (s) begin
      setup_start <= 1'b1;
      @(posedge ref_clk);
      setup_start <= 1'b0;
      @(posedge ref_clk);
    end
    {txn_valid, txn_pid, txn_ep, txn_count, txn_crc_ok, txn_toggle} <= {1'b1, p, e, c, ok, t};
    @(posedge ref_clk);
    txn_valid <= 1'b0;
    // Released count lines never show the old value
    txn_count <= ~c;
    @(negedge ref_clk);
    got = ans_valid ? ans_code : R_IGNORE;
    got_int = ep_int;
    got_cnt = {ans_toggle, 1'b0, ans_count};
    if (ans_valid && (ans_code == R_TX0 || ans_code == R_TXCNT)) begin
      repeat (ACK_DLY) @(posedge ref_clk);
      in_ack <= 1'b1;
      @(posedge ref_clk);
      in_ack <= 1'b0;
    end
    @(posedge ref_clk);
  endtask : send
endmodule : uepmc_host_model
`default_nettype wire

/* File: tb/usb_endpoint_mode_count_engine_bench.sv */
// Self-checking bench for the endpoint mode and count engine
`default_nettype none
module usb_endpoint_mode_count_engine_bench import uepmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] ep;
    logic [7:0] mode;
    logic [1:0] pid;
    logic tog;
    uepmc_resp_e code;
    logic [7:0] nm;
  } uepmc_row_s;
  logic ref_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [8:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, txn_pid;
  logic txn_valid, txn_crc_ok, txn_toggle, setup_start, in_ack, ans_valid, ans_toggle;
  logic [2:0] txn_ep;
  logic [5:0] txn_count, ans_count;
  uepmc_resp_e ans_code;
  logic [4:0] ep_int;
  logic ep0_buf_lock;
  logic [7:0] d;
  logic [1:0] r;
  int errors = 0, checked = 0;
  logic [8:0] cnt_a [5] = '{9'h044, 9'h04C, 9'h054, 9'h104, 9'h10C};
  logic [8:0] mode_a [5] = '{9'h048, 9'h050, 9'h058, 9'h108, 9'h110};
  // 8'hFF: mode readback not judged; control modes only on endpoint zero
  uepmc_row_s rows [25] = '{
    '{3'h1, 8'h00, P_IN, 1'b1, R_IGNORE, 8'h00}, '{3'h1, 8'h07, P_IN, 1'b1, R_TXCNT, 8'h07},
    '{3'h1, 8'h07, P_OUT, 1'b1, R_IGNORE, 8'h07}, '{3'h3, 8'h05, P_IN, 1'b1, R_IGNORE, 8'h05},
    '{3'h4, 8'h08, P_OUT, 1'b1, R_NAK, 8'h08}, '{3'h1, 8'h09, P_OUT, 1'b1, R_ACK, 8'h18},
    '{3'h1, 8'h89, P_OUT, 1'b1, R_STALL, 8'h89}, '{3'h2, 8'h0C, P_IN, 1'b1, R_NAK, 8'h0C},
    '{3'h1, 8'h0D, P_IN, 1'b1, R_TXCNT, 8'h1C}, '{3'h1, 8'h8D, P_IN, 1'b1, R_STALL, 8'h8D},
    '{3'h1, 8'h0D, P_OUT, 1'b1, R_IGNORE, 8'h0D}, '{3'h0, 8'h01, P_IN, 1'b1, R_NAK, 8'h41},
    '{3'h0, 8'h02, P_IN, 1'b1, R_STALL, 8'h42}, '{3'h0, 8'h02, P_OUT, 1'b1, R_ACK, 8'h32},
    '{3'h0, 8'h02, P_OUT, 1'b0, R_STALL, 8'h22}, '{3'h0, 8'h03, P_OUT, 1'b1, R_STALL, 8'h23},
    '{3'h0, 8'h04, P_IN, 1'b1, R_IGNORE, 8'h04}, '{3'h0, 8'h06, P_IN, 1'b1, R_TX0, 8'hFF},
    '{3'h0, 8'h06, P_OUT, 1'b1, R_STALL, 8'h26}, '{3'h0, 8'h0A, P_OUT, 1'b1, R_NAK, 8'h2A},
    '{3'h0, 8'h0B, P_OUT, 1'b1, R_ACK, 8'h3A}, '{3'h0, 8'h0E, P_IN, 1'b1, R_NAK, 8'h4E},
    '{3'h0, 8'h0F, P_OUT, 1'b0, R_STALL, 8'hFF}, '{3'h0, 8'h0A, P_IN, 1'b1, R_TX0, 8'hFF},
    '{3'h1, 8'h00, P_OUT, 1'b1, R_IGNORE, 8'h00}};
  uepmc_engine u_uepmc_engine (.*);
  uepmc_host_model u_uepmc_host_model (.*);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: value %h, expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_ans(input uepmc_resp_e g, input uepmc_resp_e e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: answer %0d, expected %0d", $time, g, e);
    end
  endtask : chk_ans
  task automatic bus_wait(input logic v, input int n);
    if (v !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: bus answer missing after %0d cycles", $time, n);
      tally_and_finish();
    end
  endtask : bus_wait
  task automatic axi_wr(input logic [8:0] a, input logic [7:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    bus_wait(s_axi_bvalid, n);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [8:0] a, output logic [7:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    bus_wait(s_axi_rvalid, n);
    {v, rs} = {s_axi_rdata[7:0], s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_rd
  task automatic run_row(input uepmc_row_s w);
    axi_wr(mode_a[w.ep], w.mode, r);
    u_uepmc_host_model.send(w.pid, w.ep, 6'h02, 1'b1, w.tog, 1'b0);
    chk_ans(u_uepmc_host_model.got, w.code);
    axi_rd(mode_a[w.ep], d, r);
    if (w.nm !== 8'hFF) chk_val(d, w.nm);
    axi_rd(cnt_a[w.ep], d, r);
  endtask : run_row
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    axi_rd(9'h050, d, r);
    chk_val(d, 8'h00);
    axi_rd(9'h1FC, d, r);
    chk_val({6'h0, r}, 8'h02);
    foreach (rows[i]) run_row(rows[i]);
    // Setup with good data, then writes while locked
    axi_wr(9'h048, 8'h03, r);
    u_uepmc_host_model.send(P_SETUP, 3'h0, 6'h0A, 1'b1, 1'b1, 1'b1);
    chk_ans(u_uepmc_host_model.got, R_ACK);
    chk_val({3'h0, u_uepmc_host_model.got_int}, 8'h01);
    chk_val({7'h0, ep0_buf_lock}, 8'h01);
    axi_wr(9'h044, 8'h05, r);
    axi_wr(9'h048, 8'h00, r);
    axi_rd(9'h044, d, r);
    chk_val(d, 8'hCA);
    axi_rd(9'h048, d, r);
    chk_val(d, 8'h91);
    axi_wr(9'h044, 8'h05, r);
    axi_wr(9'h048, 8'h01, r);
    axi_rd(9'h044, d, r);
    chk_val(d, 8'h05);
    axi_rd(9'h048, d, r);
    chk_val({d, 7'h0, ep0_buf_lock}, 16'h0100);
    // Setup with a corrupt CRC still interrupts
    u_uepmc_host_model.send(P_SETUP, 3'h0, 6'h0A, 1'b0, 1'b0, 1'b1);
    chk_val({3'h0, u_uepmc_host_model.got_int}, 8'h01);
    axi_rd(9'h044, d, r);
    chk_val(d, 8'h0A);
    axi_wr(9'h050, 8'h09, r);
    u_uepmc_host_model.send(P_OUT, 3'h1, 6'h06, 1'b1, 1'b0, 1'b0);
    axi_wr(9'h04C, 8'hA0, r);
    axi_rd(9'h04C, d, r);
    chk_val(d, 8'hA0);
    axi_wr(9'h050, 8'h0D, r);
    u_uepmc_host_model.send(P_IN, 3'h1, 6'h00, 1'b1, 1'b0, 1'b0);
    chk_val(u_uepmc_host_model.got_cnt, 8'hA0);
    u_uepmc_host_model.send(P_IN, 3'h5, 6'h00, 1'b1, 1'b1, 1'b0);
    chk_ans(u_uepmc_host_model.got, R_IGNORE);
    axi_wr(9'h1FC, 8'h00, r);
    chk_val({6'h0, r}, 8'h02);
    tally_and_finish();
  end
endmodule : usb_endpoint_mode_count_engine_bench
`default_nettype wire
